/* hw/seg_addr_pkg.sv */
// Shared types and constants for the segment address generator
package seg_addr_pkg;

    // ------------------------------------------------------------
    // Widths and field positions
    // ------------------------------------------------------------
    localparam int ADDR_W       = 32;
    localparam int SEL_W        = 16;
    localparam int SEL_INDEX_W  = 14;
    localparam int PORT_W       = 16;
    localparam int IMM_PORT_W   = 8;
    localparam int REAL_SHIFT   = 4;
    localparam int REG_COUNT    = 8;
    localparam int SEG_COUNT    = 6;

    localparam logic [ADDR_W-1:0] REAL_LIMIT   = 32'h0000_FFFF;
    localparam logic [ADDR_W-1:0] ZERO_ADDR    = 32'h0000_0000;
    localparam logic [PORT_W-1:0] RSVD_PORT_LO = 16'h00F8;
    localparam logic [PORT_W-1:0] RSVD_PORT_HI = 16'h00FF;

    // Memory-or-I/O space select levels
    localparam logic SPACE_MEM = 1'b1;
    localparam logic SPACE_IO  = 1'b0;

    // ------------------------------------------------------------
    // Segment register codes
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        SEG_EXTRA  = 3'h0,
        SEG_CODE   = 3'h1,
        SEG_STACK  = 3'h2,
        SEG_DATA   = 3'h3,
        SEG_ADD_A  = 3'h4,
        SEG_ADD_B  = 3'h5
    } seg_sel_t;

    // General register index that serves as stack pointer base
    localparam logic [2:0] STACK_POINTER_IDX = 3'h4;

    // Scale factor codes: shift of 0,1,2,3 gives 1,2,4,8
    typedef enum logic [1:0] {
        SCALE_1 = 2'h0,
        SCALE_2 = 2'h1,
        SCALE_4 = 2'h2,
        SCALE_8 = 2'h3
    } scale_t;

    // Kind of access requested
    typedef enum logic [2:0] {
        REF_FETCH   = 3'h0,
        REF_STACK   = 3'h1,
        REF_DATA    = 3'h2,
        REF_STRDEST = 3'h3,
        REF_IO_IMM  = 3'h4,
        REF_IO_PORT = 3'h5
    } ref_kind_t;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        ref_kind_t          kind;
        logic               override_en;
        seg_sel_t           override_seg;
        logic               addr32;
        logic               use_base;
        logic [2:0]         base_idx;
        logic               use_index;
        logic [2:0]         index_idx;
        scale_t             scale;
        logic [ADDR_W-1:0]  disp;
        logic [IMM_PORT_W-1:0] imm_port;
    } addr_req_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic              space;
        logic              fault;
        logic              reserved_port;
        seg_sel_t          seg;
    } addr_rsp_t;

endpackage

/* hw/offset_adder.sv */
// Effective offset adder: base plus scaled index plus displacement
`timescale 1ns/100ps
module offset_adder
    import seg_addr_pkg::*;
(
    // Operand components
    input  wire logic [ADDR_W-1:0] base_val,
    input  wire logic [ADDR_W-1:0] index_val,
    input  wire logic              use_base,
    input  wire logic              use_index,
    input  wire scale_t            scale,
    input  wire logic              addr32,
    input  wire logic [ADDR_W-1:0] disp,
    // Result
    output logic      [ADDR_W-1:0] offset
);

    // ------------------------------------------------------------
    // Component selection
    // ------------------------------------------------------------
    wire logic [ADDR_W-1:0] base_term;
    wire logic [ADDR_W-1:0] index_term;
    wire logic [ADDR_W-1:0] scaled_index;
    wire logic [1:0]        shift_amt;

    assign base_term    = use_base ? base_val : ZERO_ADDR;
    // No scaling in 16-bit addressing
    assign shift_amt    = addr32 ? scale : 2'h0;
    assign scaled_index = index_val << shift_amt;
    assign index_term   = use_index ? scaled_index : ZERO_ADDR;

    // Wraps modulo 2^32, as the offset space does
    assign offset = base_term + index_term + disp;

endmodule

/* hw/segment_address_generator.sv */
// Segment selection, linear and physical address generation, I/O port addressing
// ------------------------------------------------------------
// ------------------------------------------------------------
`timescale 1ns/100ps
module segment_address_generator
    import seg_addr_pkg::*;
(
    // Clock and reset
    input  wire logic              clock,
    input  wire logic              reset,
    // Processor state
    input  wire logic              protected_mode,
    input  wire logic              paging_enable,
    // Segment selector loads
    input  wire logic              seg_load,
    input  wire seg_sel_t          seg_load_idx,
    input  wire logic [SEL_W-1:0]  seg_load_selector,
    input  wire logic [ADDR_W-1:0] seg_load_base,
    // General register file and instruction pointer
    input  wire logic [ADDR_W-1:0] gp_regs [REG_COUNT],
    input  wire logic [ADDR_W-1:0] instr_pointer,
    input  wire logic [ADDR_W-1:0] destination_index_reg,
    input  wire logic [PORT_W-1:0] port_index_reg,
    // Address request
    input  wire logic              req_valid,
    input  wire addr_req_t         req,
    // Address result
    output addr_rsp_t              rsp,
    output logic                   rsp_valid,
    output logic [SEL_INDEX_W-1:0] rsp_selector_index
);

    // ------------------------------------------------------------
    // Segment register storage
    // ------------------------------------------------------------
    // Six selectors with their cached linear bases; bases may freely
    // overlap, any may be zero, so no checks are made on them.
    logic [SEL_W-1:0]  selector   [SEG_COUNT];
    logic [ADDR_W-1:0] seg_base   [SEG_COUNT];

    genvar g;
    generate
        for (g = 0; g < SEG_COUNT; g++) begin : g_seg
            wire logic hit;
            assign hit = seg_load && (seg_load_idx == seg_sel_t'(g));
            always_ff @(posedge clock) begin
                if (reset) begin
                    selector[g] <= 16'h0000;
                    seg_base[g] <= ZERO_ADDR;
                end else if (hit) begin
                    selector[g] <= seg_load_selector;
                    seg_base[g] <= seg_load_base;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Reference classification
    // ------------------------------------------------------------
    wire logic is_fetch;
    wire logic is_stack;
    wire logic is_data;
    wire logic is_strdest;
    wire logic is_io_imm;
    wire logic is_io_port;
    wire logic is_io;

    assign is_fetch   = (req.kind == REF_FETCH);
    assign is_stack   = (req.kind == REF_STACK);
    assign is_data    = (req.kind == REF_DATA);
    assign is_strdest = (req.kind == REF_STRDEST);
    assign is_io_imm  = (req.kind == REF_IO_IMM);
    assign is_io_port = (req.kind == REF_IO_PORT);
    assign is_io      = is_io_imm || is_io_port;

    // ------------------------------------------------------------
    // Segment selection
    // ------------------------------------------------------------
    wire logic     base_is_sp;
    wire seg_sel_t data_default;
    wire seg_sel_t data_seg;
    wire seg_sel_t chosen_seg;

    // Stack-pointer based data defaults to the stack segment
    assign base_is_sp   = req.use_base && (req.base_idx == STACK_POINTER_IDX);
    assign data_default = base_is_sp ? SEG_STACK : SEG_DATA;
    // For data references, override is the only path to extra and additional segments
    assign data_seg     = req.override_en ? req.override_seg : data_default;

    // Fetch, push/pop and string destination ignore any override
    assign chosen_seg = is_fetch   ? SEG_CODE  :
                        is_stack   ? SEG_STACK :
                        is_strdest ? SEG_EXTRA :
                                     data_seg;

    // ------------------------------------------------------------
    // Effective offset
    // ------------------------------------------------------------
    wire logic [ADDR_W-1:0] base_sel;
    wire logic [ADDR_W-1:0] index_sel;
    wire logic [ADDR_W-1:0] comp_offset;
    wire logic [ADDR_W-1:0] eff_offset;

    // String destination uses the destination index as its base
    assign base_sel  = is_strdest ? destination_index_reg : gp_regs[req.base_idx];
    assign index_sel = gp_regs[req.index_idx];

    offset_adder u_offset_adder (
        .base_val  (base_sel),
        .index_val (index_sel),
        .use_base  (req.use_base || is_strdest),
        .use_index (req.use_index && !is_strdest),
        .scale     (req.scale),
        .addr32    (req.addr32),
        .disp      (is_strdest ? ZERO_ADDR : req.disp),
        .offset    (comp_offset)
    );

    // Fetch offset is the instruction pointer
    assign eff_offset = is_fetch ? instr_pointer : comp_offset;

    // ------------------------------------------------------------
    // Linear address
    // ------------------------------------------------------------
    wire logic [SEL_W-1:0]  seg_selector;
    wire logic [ADDR_W-1:0] real_base;
    wire logic [ADDR_W-1:0] linear_addr;
    wire logic              real_overflow;

    assign seg_selector  = selector[chosen_seg];
    assign real_base     = {{(ADDR_W-SEL_W){1'b0}}, seg_selector} << REAL_SHIFT;
    assign linear_addr   = protected_mode ? (seg_base[chosen_seg] + eff_offset)
                                          : (real_base + eff_offset);
    // Address-size prefix does not lift the 64K real-mode limit
    assign real_overflow = !protected_mode && !is_io && (eff_offset > REAL_LIMIT);

    // ------------------------------------------------------------
    // Port address
    // ------------------------------------------------------------
    wire logic [PORT_W-1:0] port_addr;
    wire logic [ADDR_W-1:0] port_phys;
    wire logic              port_reserved;

    assign port_addr     = is_io_imm ? {{(PORT_W-IMM_PORT_W){1'b0}}, req.imm_port}
                                     : port_index_reg;
    // Upper address lines zero, no segment or page translation
    assign port_phys     = {{(ADDR_W-PORT_W){1'b0}}, port_addr};
    // Flagged only; the reserved range is the system's to avoid
    assign port_reserved = (port_addr >= RSVD_PORT_LO) && (port_addr <= RSVD_PORT_HI);

    // ------------------------------------------------------------
    // Physical address and result
    // ------------------------------------------------------------
    // Paging translation lives elsewhere; with paging off this is the
    // physical address, with it on the page unit consumes it as linear.
    wire logic [ADDR_W-1:0] phys_addr;
    wire addr_rsp_t         next_rsp;
    wire logic [SEL_INDEX_W-1:0] next_sel_index;

    assign phys_addr = is_io ? port_phys : linear_addr;

    assign next_rsp.addr          = real_overflow ? ZERO_ADDR : phys_addr;
    assign next_rsp.space         = is_io ? SPACE_IO : SPACE_MEM;
    assign next_rsp.fault         = real_overflow;
    assign next_rsp.reserved_port = is_io && port_reserved;
    assign next_rsp.seg           = chosen_seg;
    // Top fourteen selector bits index one of 16K descriptors
    assign next_sel_index = seg_selector[SEL_W-1 -: SEL_INDEX_W];

    wire logic unused_ok;
    assign unused_ok = paging_enable & is_data;

    always_ff @(posedge clock) begin
        if (reset) begin
            rsp                <= '{addr: ZERO_ADDR, space: SPACE_MEM, fault: 1'b0,
                                    reserved_port: 1'b0, seg: SEG_EXTRA};
            rsp_valid          <= 1'b0;
            rsp_selector_index <= '0;
        end else begin
            rsp_valid          <= req_valid;
            if (req_valid) begin
                rsp                <= next_rsp;
                rsp_selector_index <= next_sel_index;
            end
        end
    end

endmodule

/* tb/seg_addr_props.sv */
// Port-level checks for the segment address generator
`timescale 1ns/100ps
module seg_addr_props
    import seg_addr_pkg::*;
(
    // Clock and reset
    input wire logic              clock,
    input wire logic              reset,
    // Request side
    input wire logic              req_valid,
    input wire addr_req_t         req,
    input wire logic [PORT_W-1:0] port_index_reg,
    // Result side
    input wire addr_rsp_t         rsp,
    input wire logic              rsp_valid
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    wire is_io = (req.kind == REF_IO_IMM) || (req.kind == REF_IO_PORT);

    a_answer_next_cycle: assert property (req_valid |=> rsp_valid)
        else $error("no answer one cycle after a request");
    a_no_idle_answer: assert property (!req_valid |=> !rsp_valid)
        else $error("answer without a request");
    a_io_space_low: assert property (req_valid && is_io |=> rsp.space == SPACE_IO)
        else $error("space select not low on port cycle");
    a_mem_space_high: assert property (req_valid && !is_io |=> rsp.space == SPACE_MEM)
        else $error("space select not high on memory cycle");
    a_fetch_code_seg: assert property (req_valid && req.kind == REF_FETCH |=> rsp.seg == SEG_CODE)
        else $error("fetch not on code segment");
    a_stack_seg_kept: assert property (req_valid && req.kind == REF_STACK |=> rsp.seg == SEG_STACK)
        else $error("push or pop not on stack segment");
    a_strdest_extra: assert property (req_valid && req.kind == REF_STRDEST |=> rsp.seg == SEG_EXTRA)
        else $error("string destination not on extra segment");
    a_override_wins: assert property (req_valid && req.kind == REF_DATA && req.override_en
        |=> rsp.seg == $past(req.override_seg))
        else $error("data override ignored");
    a_port_index_direct: assert property (req_valid && req.kind == REF_IO_PORT
        |=> rsp.addr == {16'h0000, $past(port_index_reg)})
        else $error("port index address altered");
    a_imm_zero_ext: assert property (req_valid && req.kind == REF_IO_IMM
        |=> rsp.addr == {24'h00_0000, $past(req.imm_port)})
        else $error("immediate port not zero extended");

    c_port_cycle: cover property (req_valid && req.kind == REF_IO_PORT);
    c_real_fault: cover property (rsp_valid && rsp.fault);
    c_data_override: cover property (req_valid && req.kind == REF_DATA && req.override_en);
endmodule
bind segment_address_generator seg_addr_props seg_addr_props_inst (.clock(clock), .reset(reset),
    .req_valid(req_valid), .req(req), .port_index_reg(port_index_reg), .rsp(rsp), .rsp_valid(rsp_valid));

/* tb/bus_partner.sv */
// Memory and port bus model that counts decoded cycles
`timescale 1ns/100ps
module bus_partner
    import seg_addr_pkg::*;
(
    // Clock and reset
    input wire logic      clock,
    input wire logic      reset,
    // Cycles from the generator
    input wire addr_rsp_t rsp,
    input wire logic      rsp_valid,
    // Counts seen
    output int            mem_cycles,
    output int            io_cycles,
    output int            reserved_hits
);
    // Only the low 16 lines decode ports; no peripheral sits in the reserved range
    wire in_rsvd = rsp.addr[15:0] >= RSVD_PORT_LO && rsp.addr[15:0] <= RSVD_PORT_HI;
    always @(posedge clock) begin
        if (reset) begin
            mem_cycles <= 0;
            io_cycles <= 0;
            reserved_hits <= 0;
        end else if (rsp_valid && rsp.space == SPACE_IO) begin
            io_cycles <= io_cycles + 1;
            reserved_hits <= reserved_hits + int'(in_rsvd);
        end else if (rsp_valid) begin
            mem_cycles <= mem_cycles + 1;
        end
    end
endmodule

/* tb/tb.sv */
// Self-checking bench for the segment address generator
`timescale 1ns/100ps
module tb
    import seg_addr_pkg::*;
;
    logic clock = 1'b0, reset = 1'b1, protected_mode = 1'b0, paging_enable = 1'b0;
    logic seg_load = 1'b0, req_valid = 1'b0, rsp_valid;
    seg_sel_t seg_load_idx = SEG_EXTRA;
    logic [SEL_W-1:0] seg_load_selector = 16'h0000;
    logic [ADDR_W-1:0] seg_load_base = 32'h0000_0000, instr_pointer = 32'h0000_1000;
    logic [ADDR_W-1:0] destination_index_reg = 32'h0000_0300;
    logic [ADDR_W-1:0] gp_regs [REG_COUNT];
    logic [PORT_W-1:0] port_index_reg = 16'hABCD;
    addr_req_t req = '0;
    addr_rsp_t rsp;
    logic [SEL_INDEX_W-1:0] rsp_selector_index;
    int num_errors = 0, check_count = 0, mem_cycles, io_cycles, reserved_hits;

    always #5 clock = ~clock;

    segment_address_generator segment_address_generator_inst (.clock(clock), .reset(reset),
        .protected_mode(protected_mode), .paging_enable(paging_enable), .seg_load(seg_load),
        .seg_load_idx(seg_load_idx), .seg_load_selector(seg_load_selector), .seg_load_base(seg_load_base),
        .gp_regs(gp_regs), .instr_pointer(instr_pointer), .destination_index_reg(destination_index_reg),
        .port_index_reg(port_index_reg), .req_valid(req_valid), .req(req), .rsp(rsp),
        .rsp_valid(rsp_valid), .rsp_selector_index(rsp_selector_index));
    bus_partner bus_partner_inst (.clock(clock), .reset(reset), .rsp(rsp), .rsp_valid(rsp_valid),
        .mem_cycles(mem_cycles), .io_cycles(io_cycles), .reserved_hits(reserved_hits));

    task chk(input logic [ADDR_W-1:0] seen, input logic [ADDR_W-1:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task load(input seg_sel_t i, input logic [SEL_W-1:0] s, input logic [ADDR_W-1:0] b);
        @(negedge clock);
        seg_load = 1'b1;
        seg_load_idx = i;
        seg_load_selector = s;
        seg_load_base = b;
        @(negedge clock);
        seg_load = 1'b0;
    endtask

    // Request is taken at the rising edge between the two falling edges
    task issue(input addr_req_t r);
        @(negedge clock);
        req = r;
        req_valid = 1'b1;
        @(negedge clock);
        req_valid = 1'b0;
        chk(rsp_valid, 1'b1);
    endtask

    function addr_req_t mk(input ref_kind_t k, input logic oe, input logic [ADDR_W-1:0] d);
        mk = '0;
        mk.kind = k;
        mk.override_en = oe;
        mk.override_seg = SEG_ADD_B;
        mk.addr32 = 1'b1;
        mk.use_base = 1'b1;
        mk.base_idx = STACK_POINTER_IDX;
        mk.disp = d;
    endfunction

    task test_real;
        addr_req_t r;
        load(SEG_DATA, 16'h1234, 32'h0000_0000);
        r = mk(REF_DATA, 1'b0, 32'h0000_0008);
        r.base_idx = 3'h1;
        r.use_index = 1'b1;
        r.index_idx = 3'h2;
        r.scale = SCALE_4;
        issue(r);
        chk(rsp.addr, 32'h0001_2488);
        chk(rsp.fault, 1'b0);
        chk(rsp.seg, SEG_DATA);
        chk(rsp_selector_index, 14'h048D);
        r.addr32 = 1'b0;
        issue(r);
        chk(rsp.addr, 32'h0001_2458);
        r.use_base = 1'b0;
        r.use_index = 1'b0;
        r.disp = 32'h0001_0000;
        issue(r);
        chk(rsp.fault, 1'b1);
        $display("real mode test done");
    endtask

    task pcase(input ref_kind_t k, input logic oe, input seg_sel_t s, input logic [ADDR_W-1:0] a);
        issue(mk(k, oe, 32'h0000_0000));
        chk(rsp.seg, s);
        chk(rsp.addr, a);
        chk(rsp.space, SPACE_MEM);
    endtask

    task test_prot;
        protected_mode = 1'b1;
        load(SEG_STACK, 16'h0010, 32'h4000_0000);
        load(SEG_EXTRA, 16'h0020, 32'h5000_0000);
        load(SEG_CODE, 16'h0030, 32'h6000_0000);
        load(SEG_ADD_B, 16'h0040, 32'h7000_0000);
        pcase(REF_DATA, 1'b0, SEG_STACK, 32'h4000_0200);
        pcase(REF_DATA, 1'b1, SEG_ADD_B, 32'h7000_0200);
        pcase(REF_FETCH, 1'b1, SEG_CODE, 32'h6000_1000);
        pcase(REF_STACK, 1'b1, SEG_STACK, 32'h4000_0200);
        pcase(REF_STRDEST, 1'b1, SEG_EXTRA, 32'h5000_0300);
        $display("protected mode test done");
    endtask

    task test_io;
        addr_req_t r;
        r = mk(REF_IO_IMM, 1'b0, 32'h0000_0000);
        r.imm_port = 8'hF8;
        issue(r);
        chk(rsp.addr, 32'h0000_00F8);
        chk(rsp.space, SPACE_IO);
        chk(rsp.reserved_port, 1'b1);
        issue(mk(REF_IO_PORT, 1'b1, 32'hFFFF_FFFF));
        chk(rsp.addr, 32'h0000_ABCD);
        chk(rsp.reserved_port, 1'b0);
        chk(rsp.space, SPACE_IO);
        @(negedge clock);
        chk(io_cycles, 32'h0000_0002);
        chk(reserved_hits, 32'h0000_0001);
        chk(mem_cycles, 32'h0000_0008);
        $display("port test done");
    endtask

    task wrap_up;
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        for (int i = 0; i < REG_COUNT; i++) begin
            gp_regs[i] = 32'h0000_0000;
        end
        gp_regs[1] = 32'h0000_0100;
        gp_regs[2] = 32'h0000_0010;
        gp_regs[4] = 32'h0000_0200;
        repeat (5) @(posedge clock);
        @(negedge clock);
        reset = 1'b0;
        test_real;
        test_prot;
        test_io;
        wrap_up;
    end

    // Whole run needs well under a hundred cycles
    initial begin
        repeat (2000) @(posedge clock);
        num_errors++;
        wrap_up;
    end
endmodule
